// file: rtl/mmbd_core_map.sv
// Program counter, bank select and data memory map for a small core.
// Assumes the fetch and data access logic run on mclk and peripherals
// answer a registered read strobe within the same cycle.
// Notes on behaviour
// [RQ1] - Program fetch and data access use separate ports and may act in one cycle.
// [RQ2] - The program counter is 13 bits and spans eight thousand words.
// [RQ3] - Only 2K words exist, so fetch addresses above 07FFh wrap onto them.
// [RQ4] - Every reset starts fetching at program address zero.
// [RQ5] - Taking an interrupt loads program address four.
// [RQ6] - Status bits six and five select the bank; codes 10 and 11 are absent banks.
// [RQ7] - Software should keep the upper bank select bit clear.
// [RQ8] - Each bank has 128 offsets whose low part holds special function registers.
// [RQ9] - Static RAM sits at 20h-7Fh in bank zero and A0h-BFh in bank one.
// [RQ10] - Core registers appear at the same offset in both banks with one storage.
// [RQ11] - Every location is reachable directly with the bank bits or via the pointer.
// [RQ12] - Unimplemented locations read as zero.
// [RQ13] - Without the converter its register locations read as zero.
// [RQ14] - The indirect port at offset zero has no storage and redirects the access.
// [RQ15] - The indirect port reaches the address held in the pointer, bit seven the bank.
// [RQ16] - A write to the counter low byte loads the upper bits from the high latch.
`timescale 1ns/1ps
module mmbd_core_map (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Program fetch bus
    input wire logic pc_step,
    input wire logic irq_take,
    output logic [10:0] prog_addr,
    output logic [12:0] prog_counter,
    // Data access bus
    input wire logic [6:0] dat_ofs,
    input wire logic dat_rd,
    input wire logic dat_wr,
    input wire logic [7:0] dat_wdata,
    output logic [7:0] dat_rdata,
    output logic dat_rvalid,
    // Peripheral window
    input wire logic conv_present,
    input wire logic [7:0] periph_rdata,
    output logic [7:0] periph_addr,
    output logic periph_rd,
    output logic periph_wr,
    output logic [7:0] periph_wdata,
    // Core register views
    output logic [7:0] core_status,
    output logic [7:0] int_ctrl
);
    logic [12:0] pc;
    logic [7:0] pointer;
    logic [4:0] pc_latch;
    logic [7:0] ram [mmbd_pkg::GPR_DEPTH];
    logic s1_rd;
    logic s1_periph;
    logic [7:0] s1_data;
    logic [12:0] next_pc;
    logic [7:0] core_rdata;

    mmbd_dec_if dec ();

    mmbd_addr_decode u_decode (
        .d(dec)
    );

    // Direct access uses the bank bits; offset zero switches to the pointer
    wire use_ind = dat_ofs == mmbd_pkg::OFS_INDIRECT; // [RQ14]
    wire [1:0] dir_bank = {core_status[mmbd_pkg::BANK_HIGH_BIT],
                           core_status[mmbd_pkg::BANK_LOW_BIT]}; // [RQ6]
    wire [1:0] ind_bank = {1'b0, pointer[mmbd_pkg::PTR_BANK_BIT]}; // [RQ15]
    wire [1:0] eff_bank = use_ind ? ind_bank : dir_bank; // [RQ11]
    wire [6:0] eff_ofs = use_ind ? pointer[6:0] : dat_ofs; // [RQ15]

    assign dec.bank = eff_bank;
    assign dec.ofs = eff_ofs;
    assign dec.conv_en = conv_present; // [RQ13]

    wire acc = dat_rd | dat_wr;
    wire wr_core = dat_wr & dec.is_core;
    wire pcl_wr = wr_core & (eff_ofs == mmbd_pkg::OFS_PC_LOW);
    wire stat_wr = wr_core & (eff_ofs == mmbd_pkg::OFS_STATUS);
    wire ptr_wr = wr_core & (eff_ofs == mmbd_pkg::OFS_POINTER);
    wire lat_wr = wr_core & (eff_ofs == mmbd_pkg::OFS_PC_LATCH);
    wire ic_wr = wr_core & (eff_ofs == mmbd_pkg::OFS_INT_CTRL);
    wire gpr_wr = dat_wr & dec.is_gpr;
    wire unimpl = ~(dec.is_core | dec.is_gpr | dec.is_periph);
    wire [7:0] status_new = (core_status & ~mmbd_pkg::STATUS_WMASK)
                          | (dat_wdata & mmbd_pkg::STATUS_WMASK);
    wire [12:0] jump_pc = {pc_latch, dat_wdata}; // [RQ16]

    // Interrupt beats a jump, which beats a plain step
    always_comb begin
        next_pc = pc;
        if (irq_take) begin
            next_pc = mmbd_pkg::IRQ_VECTOR; // [RQ5]
        end else if (pcl_wr) begin
            next_pc = jump_pc; // [RQ16]
        end else if (pc_step) begin
            next_pc = pc + mmbd_pkg::PC_ONE; // [RQ2]
        end
    end

    // Core register read mux; the indirect port itself holds nothing
    always_comb begin
        case (eff_ofs)
            mmbd_pkg::OFS_PC_LOW: core_rdata = pc[7:0];
            mmbd_pkg::OFS_STATUS: core_rdata = core_status;
            mmbd_pkg::OFS_POINTER: core_rdata = pointer;
            mmbd_pkg::OFS_PC_LATCH: core_rdata = {3'b000, pc_latch};
            mmbd_pkg::OFS_INT_CTRL: core_rdata = int_ctrl;
            default: core_rdata = mmbd_pkg::ZERO_BYTE; // [RQ14]
        endcase
    end

    wire [7:0] gpr_rdata = ram[dec.gpr_idx];
    wire [7:0] local_rdata = dec.is_core ? core_rdata :
                             dec.is_gpr ? gpr_rdata : mmbd_pkg::ZERO_BYTE; // [RQ12]

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pc <= mmbd_pkg::RESET_VECTOR; // [RQ4]
            prog_addr <= mmbd_pkg::RESET_VECTOR[10:0];
        end else begin
            pc <= next_pc;
            prog_addr <= next_pc[10:0]; // [RQ3]
        end
    end

    assign prog_counter = pc; // [RQ1]

    // Bank select high is kept as written; absent banks read zero apart from the mirrored core registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            core_status <= mmbd_pkg::STATUS_RST;
            pointer <= mmbd_pkg::POINTER_RST;
            pc_latch <= mmbd_pkg::PC_LATCH_RST;
            int_ctrl <= mmbd_pkg::INT_CTRL_RST;
        end else begin
            if (stat_wr) begin
                core_status <= status_new; // [RQ6] [RQ7]
            end
            if (ptr_wr) begin
                pointer <= dat_wdata;
            end
            if (lat_wr) begin
                pc_latch <= dat_wdata[4:0];
            end
            if (ic_wr) begin
                int_ctrl <= dat_wdata; // [RQ10]
            end
        end
    end

    // RAM has no reset; contents are undefined until written
    always_ff @(posedge mclk) begin
        if (gpr_wr) begin
            ram[dec.gpr_idx] <= dat_wdata; // [RQ9]
        end
    end

    // Peripheral strobes are registered so outside logic sees clean pulses
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            periph_rd <= 1'b0;
            periph_wr <= 1'b0;
            periph_addr <= mmbd_pkg::ZERO_BYTE;
            periph_wdata <= mmbd_pkg::ZERO_BYTE;
        end else begin
            periph_rd <= dat_rd & dec.is_periph;
            periph_wr <= dat_wr & dec.is_periph;
            if (acc & dec.is_periph) begin
                periph_addr <= {eff_bank[0], eff_ofs}; // [RQ8]
                periph_wdata <= dat_wdata;
            end
        end
    end

    // Local reads are held a stage so every read answers two cycles later
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s1_rd <= 1'b0;
            s1_periph <= 1'b0;
            s1_data <= mmbd_pkg::ZERO_BYTE;
            dat_rvalid <= 1'b0;
            dat_rdata <= mmbd_pkg::ZERO_BYTE;
        end else begin
            s1_rd <= dat_rd;
            s1_periph <= dat_rd & dec.is_periph;
            s1_data <= local_rdata;
            dat_rvalid <= s1_rd; // [RQ11]
            if (s1_rd) begin
                dat_rdata <= s1_periph ? periph_rdata : s1_data;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_reset_vector: assert property ($rose(resetn) |-> prog_counter == 13'h0000) // [RQ4]
        else $error("fetch does not start at zero after reset");

    chk_irq_vector_load: assert property (irq_take |=> prog_counter == 13'h0004) // [RQ5]
        else $error("interrupt did not load address four");

    chk_fetch_wrap: assert property (pc_step && !irq_take && !pcl_wr // [RQ3]
        && prog_counter == 13'h07ff |=> prog_addr == 11'h000)
        else $error("fetch address did not wrap past the last word");

    chk_fetch_with_data: assert property (pc_step && !irq_take && !pcl_wr && acc // [RQ1]
        |=> prog_counter == $past(prog_counter) + 13'h0001)
        else $error("fetch stalled by a data access");

    chk_pcl_jump_target: assert property (pcl_wr && !irq_take // [RQ16]
        |=> prog_counter == {$past(pc_latch), $past(dat_wdata)})
        else $error("jump target not built from the high latch");

    chk_read_latency: assert property (dat_rd |-> ##2 dat_rvalid) // [RQ11]
        else $error("read answer not two cycles later");

    chk_unimpl_zero: assert property (dat_rd && unimpl |-> ##2 dat_rdata == 8'h00) // [RQ12]
        else $error("unimplemented location did not read zero");

    chk_status_mirror: assert property (dat_rd && !use_ind // [RQ10]
        && dat_ofs == mmbd_pkg::OFS_STATUS |-> ##2 dat_rdata == $past(core_status, 2))
        else $error("status not shared across banks");

    chk_indirect_route: assert property (dat_rd && use_ind && dec.is_periph // [RQ15]
        |=> periph_rd && periph_addr == {$past(pointer[7]), $past(pointer[6:0])})
        else $error("indirect access not routed through the pointer");

    chk_conv_absent: assert property (dat_rd && !conv_present && !use_ind // [RQ13]
        && dat_ofs == mmbd_pkg::OFS_CONV_B |=> !periph_rd)
        else $error("absent converter location was forwarded");

    chk_bank_select: assert property (dat_rd && !use_ind && dec.is_periph // [RQ6]
        |=> periph_addr[7] == $past(core_status[5]))
        else $error("bank bit not taken from status");

    chk_step_plain: assert property (pc_step && !irq_take && !pcl_wr // [RQ2]
        |=> prog_counter == $past(prog_counter) + 13'h0001)
        else $error("plain step did not advance the counter");

    chk_jump_over_step: assert property (pcl_wr && pc_step && !irq_take // [RQ16]
        |=> prog_counter[7:0] == $past(dat_wdata))
        else $error("step won over a counter low write");

    chk_gpr_readback: assert property (dat_wr && dec.is_gpr ##1 dat_rd && dec.is_gpr // [RQ9]
        && dec.gpr_idx == $past(dec.gpr_idx) |-> ##2 dat_rdata == $past(dat_wdata, 3))
        else $error("static RAM did not return the byte written");

    chk_indirect_empty: assert property (dat_rd && use_ind // [RQ14]
        && pointer[6:0] == mmbd_pkg::OFS_INDIRECT |-> ##2 dat_rdata == 8'h00)
        else $error("indirect port through itself did not read zero");

    chk_bank_absent: assert property (dat_rd && !use_ind && dir_bank[1] // [RQ6]
        && !dec.is_core |-> ##2 dat_rdata == 8'h00)
        else $error("absent bank location did not read zero");

    chk_b1_gpr_limit: assert property (dat_rd && !use_ind && dir_bank == 2'b01 // [RQ12]
        && dat_ofs > mmbd_pkg::OFS_B1_GPR_HI |-> ##2 dat_rdata == 8'h00)
        else $error("bank one location above the RAM did not read zero");

    chk_conv_forward: assert property (dat_rd && conv_present && !use_ind // [RQ13]
        && dir_bank == 2'b01 && dat_ofs == mmbd_pkg::OFS_CONV_B
        |=> periph_rd && periph_addr == {1'b1, mmbd_pkg::OFS_CONV_B})
        else $error("present converter location was not forwarded");

    chk_periph_write: assert property (dat_wr && dec.is_periph // [RQ8]
        |=> periph_wr && periph_wdata == $past(dat_wdata))
        else $error("peripheral write not forwarded");

    chk_int_ctrl_store: assert property (ic_wr |=> int_ctrl == $past(dat_wdata)) // [RQ10]
        else $error("interrupt control write lost");

    chk_pointer_load: assert property (ptr_wr |=> pointer == $past(dat_wdata)) // [RQ15]
        else $error("pointer write lost");

    chk_bank_bits_write: assert property (stat_wr // [RQ6]
        |=> core_status[6:5] == $past(dat_wdata[6:5]))
        else $error("bank select bits not written");

    chk_rvalid_source: assert property (dat_rvalid |-> $past(dat_rd, 2)) // [RQ11]
        else $error("read answer without a request");

    cov_irq_taken: cover property (irq_take ##1 pc_step);
    cov_indirect_gpr: cover property (dat_rd && use_ind && dec.is_gpr ##2 dat_rvalid);
    cov_periph_read: cover property (periph_rd ##1 dat_rvalid);
    cov_bank1_write: cover property (gpr_wr && eff_bank == 2'b01);
    cov_indirect_periph_write: cover property (dat_wr && use_ind && dec.is_periph ##1 periph_wr);
endmodule : mmbd_core_map

// file: pkg/mmbd_pkg.sv
// Constants for the program and data memory map decode.
// Assumes a single core clock and a core that drives one data access per cycle.
package mmbd_pkg;
    localparam int PC_W = 13;
    localparam int PROG_AW = 11;
    localparam int OFS_W = 7;
    localparam int GPR_DEPTH = 128;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [12:0] PC_ONE = 13'h0001;
    // In-bank offsets of the mirrored core registers and the converter location
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PC_LOW = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
    localparam logic [6:0] OFS_INT_CTRL = 7'h0b;
    localparam logic [6:0] OFS_CONV_B = 7'h1f;
    // General purpose area limits and index shifts
    localparam logic [6:0] OFS_GPR_LO = 7'h20;
    localparam logic [6:0] OFS_B1_GPR_HI = 7'h3f;
    localparam logic [6:0] GPR_B1_SHIFT = 7'h40;
    // One bit per special function offset 00h..1Fh
    localparam logic [31:0] CORE_MAP = 32'h00000c1d;
    localparam logic [31:0] PERIPH_MAP_B0 = 32'h00ffd0e2;
    localparam logic [31:0] PERIPH_MAP_B1 = 32'h001c50e2;
    localparam logic [31:0] CONV_MAP_B0 = 32'hc0000000;
    localparam logic [31:0] CONV_MAP_B1 = 32'h80000000;
    // Status layout and values after reset
    localparam int BANK_HIGH_BIT = 6;
    localparam int BANK_LOW_BIT = 5;
    localparam int PTR_BANK_BIT = 7;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] STATUS_WMASK = 8'he7;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [4:0] PC_LATCH_RST = 5'h00;
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : mmbd_pkg

// file: pkg/mmbd_dec_if.sv
// Carrier between the map core and its address classifier.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface mmbd_dec_if;
    logic [1:0] bank;
    logic [6:0] ofs;
    logic conv_en;
    logic is_core;
    logic is_gpr;
    logic is_periph;
    logic [6:0] gpr_idx;
    modport decoder (input bank, ofs, conv_en, output is_core, is_gpr, is_periph, gpr_idx);
    modport user (output bank, ofs, conv_en, input is_core, is_gpr, is_periph, gpr_idx);
endinterface : mmbd_dec_if

// file: rtl/mmbd_addr_decode.sv
// Classifies a bank and in-bank offset into core, general purpose,
// peripheral or unimplemented space. Assumes a purely combinational use.
`timescale 1ns/1ps
module mmbd_addr_decode (
    // Classification carrier
    mmbd_dec_if.decoder d
);
    wire in_sfr = d.ofs < mmbd_pkg::OFS_GPR_LO;
    wire [4:0] sfr_bit = d.ofs[4:0];
    // Banks 2 and 3 are absent; only the mirrored core set answers there
    wire bank_impl = ~d.bank[1];
    wire [31:0] periph_map = d.bank[0] ? mmbd_pkg::PERIPH_MAP_B1 : mmbd_pkg::PERIPH_MAP_B0;
    wire [31:0] conv_map = d.bank[0] ? mmbd_pkg::CONV_MAP_B1 : mmbd_pkg::CONV_MAP_B0;
    wire periph_hit = periph_map[sfr_bit];
    wire conv_hit = d.conv_en & conv_map[sfr_bit]; // [RQ13]
    wire gpr_range = ~d.bank[0] | (d.ofs <= mmbd_pkg::OFS_B1_GPR_HI); // [RQ9]
    wire [6:0] idx_b0 = d.ofs - mmbd_pkg::OFS_GPR_LO;
    wire [6:0] idx_b1 = d.ofs + mmbd_pkg::GPR_B1_SHIFT;

    assign d.is_core = in_sfr & mmbd_pkg::CORE_MAP[sfr_bit]; // [RQ10]
    assign d.is_periph = bank_impl & in_sfr & (periph_hit | conv_hit); // [RQ8]
    assign d.is_gpr = bank_impl & ~in_sfr & gpr_range; // [RQ9]
    assign d.gpr_idx = d.bank[0] ? idx_b1 : idx_b0;
endmodule : mmbd_addr_decode

// file: verification/mmbd_periph_model.sv
// Peripheral responder standing in for the registers behind the window.
// Assumes a registered read strobe on mclk and data wanted in that cycle.
`timescale 1ns/1ps
module mmbd_periph_model (
    // Clock
    input wire logic mclk,
    // Peripheral window
    input wire logic [7:0] periph_addr,
    input wire logic periph_rd,
    output logic [7:0] periph_rdata
);
    logic [7:0] junk = 8'h3c;
    // Outside a strobe the bus carries garbage that moves every cycle
    always @(posedge mclk) junk <= junk + 8'h95;
    assign periph_rdata = periph_rd ? (periph_addr ^ 8'h5a) : junk;
endmodule : mmbd_periph_model

// file: verification/tb.sv
// Self-checking bench for the program counter and data memory map core.
// Assumes reads answer two cycles after the request edge.
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, resetn = 1'b0, pc_step = 1'b0, irq_take = 1'b0;
    logic dat_rd = 1'b0, dat_wr = 1'b0, conv_present = 1'b0;
    logic dat_rvalid, periph_rd, periph_wr;
    logic [6:0] dat_ofs = 7'h00;
    logic [7:0] dat_wdata = 8'h00, dat_rdata, periph_rdata, periph_addr, periph_wdata;
    logic [7:0] core_status, int_ctrl, rexp;
    logic [10:0] prog_addr;
    logic [12:0] prog_counter, pe;
    logic [7:0] b0 [32];
    logic [7:0] b1 [32];
    logic [7:0] q [$];
    logic [15:0] wq [$];
    logic [15:0] wexp;
    logic [7:0] lat [2] = '{8'h1f, 8'he7};
    logic [6:0] hole [6] = '{7'h08, 7'h09, 7'h0d, 7'h18, 7'h19, 7'h1d};
    int err_total = 0, n_checks = 0;
    integer seed;

    mmbd_core_map u_dut (.mclk, .resetn, .pc_step, .irq_take, .prog_addr, .prog_counter,
        .dat_ofs, .dat_rd, .dat_wr, .dat_wdata, .dat_rdata, .dat_rvalid, .conv_present,
        .periph_rdata, .periph_addr, .periph_rd, .periph_wr, .periph_wdata,
        .core_status, .int_ctrl);
    mmbd_periph_model u_periph (.mclk, .periph_addr, .periph_rd, .periph_rdata);

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] s);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic end_sim;
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // Requests are set after an edge and taken at the next one
    task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d);
        dat_wr <= w;
        dat_rd <= ~w;
        dat_ofs <= o;
        dat_wdata <= d;
        @(posedge mclk);
    endtask : acc
    task automatic wr(input logic [6:0] o, input logic [7:0] d);
        acc(1'b1, o, d);
    endtask : wr
    task automatic rd(input logic [6:0] o, input logic [7:0] e);
        q.push_back(e);
        acc(1'b0, o, 8'h00);
    endtask : rd
    task automatic pwr(input logic [6:0] o, input logic [7:0] a, input logic [7:0] d);
        wq.push_back({a, d});
        acc(1'b1, o, d);
    endtask : pwr
    task automatic idle;
        dat_rd <= 1'b0;
        dat_wr <= 1'b0;
        pc_step <= 1'b0;
        irq_take <= 1'b0;
        @(posedge mclk);
    endtask : idle

    // Oldest expected read value is matched against each answer
    always @(negedge mclk) begin
        if (dat_rvalid === 1'b1) begin
            rexp = (q.size() != 0) ? q.pop_front() : 8'hxx;
            chk("dat_rdata", {5'h00, rexp}, {5'h00, dat_rdata});
        end
        if (periph_wr === 1'b1) begin
            wexp = (wq.size() != 0) ? wq.pop_front() : 16'hxxxx;
            chk("periph_addr", {5'h00, wexp[15:8]}, {5'h00, periph_addr});
            chk("periph_wdata", {5'h00, wexp[7:0]}, {5'h00, periph_wdata});
        end
    end

    initial begin
        #(40 * 3000);
        err_total++;
        end_sim;
    end

    initial begin
        seed = 32'h846e74ef;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        chk("prog_counter", 13'h0000, prog_counter);
        chk("core_status", 13'h0018, {5'h00, core_status});
        @(posedge mclk);
        pc_step <= 1'b1;
        wr(7'h20, 8'h99);
        pc_step <= 1'b0;
        rd(7'h20, 8'h99);
        idle;
        @(negedge mclk);
        chk("prog_counter", 13'h0001, prog_counter);
        @(posedge mclk);
        irq_take <= 1'b1;
        pc_step <= 1'b1;
        @(posedge mclk);
        idle;
        @(negedge mclk);
        chk("prog_counter", 13'h0004, prog_counter);
        @(posedge mclk);
        foreach (lat[k]) begin
            wr(7'h0a, lat[k]);
            pc_step <= 1'b1;
            wr(7'h02, 8'hff);
            idle;
            @(negedge mclk);
            chk("prog_counter", {lat[k][4:0], 8'hff}, prog_counter);
            @(posedge mclk);
            pc_step <= 1'b1;
            @(posedge mclk);
            idle;
            @(negedge mclk);
            pe = {lat[k][4:0], 8'hff} + 13'h0001;
            chk("prog_counter", pe, prog_counter);
            chk("prog_addr", {2'b00, pe[10:0]}, {2'b00, prog_addr});
            @(posedge mclk);
        end
        rd(7'h03, 8'h18);
        wr(7'h03, 8'h20);
        foreach (b1[i]) begin
            b1[i] = 8'($random(seed));
            wr(7'h20 + 7'(i), b1[i]);
        end
        wr(7'h03, 8'h00);
        foreach (b0[i]) begin
            b0[i] = 8'($random(seed));
            wr(7'h20 + 7'(i), b0[i]);
        end
        wr(7'h7f, 8'hc9);
        foreach (b0[i]) rd(7'h20 + 7'(i), b0[i]);
        rd(7'h7f, 8'hc9);
        wr(7'h03, 8'h20);
        foreach (b1[i]) rd(7'h20 + 7'(i), b1[i]);
        rd(7'h40, 8'h00);
        wr(7'h40, 8'h55);
        rd(7'h40, 8'h00);
        rd(7'h7f, 8'h00);
        rd(7'h1f, 8'h00);
        wr(7'h0b, 8'hc3);
        wr(7'h04, 8'ha5);
        wr(7'h03, 8'h00);
        rd(7'h0b, 8'hc3);
        rd(7'h04, 8'ha5);
        wr(7'h00, 8'h6e);
        rd(7'h00, 8'h6e);
        foreach (hole[i]) rd(hole[i], 8'h00);
        rd(7'h1e, 8'h00);
        rd(7'h1f, 8'h00);
        conv_present <= 1'b1;
        idle;
        rd(7'h1e, 8'h1e ^ 8'h5a);
        rd(7'h05, 8'h05 ^ 8'h5a);
        pwr(7'h05, 8'h05, 8'($random(seed)));
        wr(7'h03, 8'h20);
        rd(7'h25, 8'h6e);
        rd(7'h05, 8'h85 ^ 8'h5a);
        rd(7'h1f, 8'h9f ^ 8'h5a);
        pwr(7'h05, 8'h85, 8'hc7);
        wr(7'h04, 8'h86);
        rd(7'h00, 8'h86 ^ 8'h5a);
        pwr(7'h00, 8'h86, 8'h4b);
        wr(7'h04, 8'h00);
        wr(7'h00, 8'h77);
        rd(7'h00, 8'h00);
        // Upper bank bit set on purpose to reach an absent bank
        wr(7'h03, 8'h40);
        rd(7'h20, 8'h00);
        rd(7'h03, 8'h58);
        rd(7'h0b, 8'hc3);
        wr(7'h03, 8'h60);
        rd(7'h03, 8'h78);
        rd(7'h25, 8'h00);
        repeat (4) idle;
        @(negedge mclk);
        chk("int_ctrl", 13'h00c3, {5'h00, int_ctrl});
        chk("pending", 13'h0000, 13'(q.size()));
        chk("pending_wr", 13'h0000, 13'(wq.size()));
        @(posedge mclk);
        resetn <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk("prog_counter", 13'h0000, prog_counter);
        chk("core_status", 13'h0018, {5'h00, core_status});
        @(posedge mclk);
        resetn <= 1'b1;
        rd(7'h03, 8'h18);
        rd(7'h02, 8'h00);
        repeat (4) idle;
        @(negedge mclk);
        chk("pending", 13'h0000, 13'(q.size()));
        end_sim;
    end
endmodule : tb
